// [rtl/idap_indirect_port.sv]
// indirect data-memory access through pointer zero, reached over axi4-lite
// Overview of operation
// - plain port uses pointer, pointer unchanged
// - post-increment port: access then pointer plus one
// - pre-increment port: pointer plus one, then access
// - ports store nothing; data goes to memory
// - post-decrement port: access then pointer minus one
// - plus-working port addresses pointer plus working register
// - pointer is low byte plus MEM_ADDR_W-8 high bits (four by default)
`timescale 1ns/1ps

module idap_indirect_port #(
  parameter int MEM_ADDR_W = idap_pkg::DEF_MEM_ADDR_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // data memory
  output logic [MEM_ADDR_W-1:0] mem_addr,
  output logic mem_wr,
  output logic mem_rd,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (MEM_ADDR_W < 9 || MEM_ADDR_W > 16)
  begin : g_bad_width
    $error("MEM_ADDR_W must lie between 9 and 16");
  end

  localparam int HIGH_W = MEM_ADDR_W - idap_pkg::BYTE_W;

  // ****************************************
  // state
  // ****************************************
  idap_pkg::idap_state_t state_r, state_nxt;
  logic [MEM_ADDR_W-1:0] ptr_r, ptr_nxt;
  logic [7:0] working_r, working_nxt;
  logic [MEM_ADDR_W-1:0] mem_addr_r, mem_addr_nxt;
  logic mem_wr_r, mem_wr_nxt;
  logic mem_rd_r, mem_rd_nxt;
  logic [7:0] mem_wdata_r, mem_wdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] resp_r, resp_nxt;

  // ****************************************
  // address decode
  // ****************************************
  logic wr_take;
  logic rd_take;
  logic [7:0] acc_addr;
  idap_pkg::idap_port_mode_t acc_mode;
  logic acc_ptr_low;
  logic acc_ptr_high;
  logic acc_working;
  logic acc_mapped;
  logic [MEM_ADDR_W-1:0] ptr_inc;
  logic [MEM_ADDR_W-1:0] ptr_dec;
  logic [MEM_ADDR_W-1:0] ptr_plus_w;
  logic [MEM_ADDR_W-1:0] acc_mem_addr;
  logic [MEM_ADDR_W-1:0] acc_ptr_after;

  // one transfer at a time; a write offered together with a read goes first
  assign wr_take = (state_r == idap_pkg::ST_IDLE) && awvalid && wvalid;
  assign rd_take = (state_r == idap_pkg::ST_IDLE) && arvalid && !(awvalid && wvalid);
  assign awready = wr_take;
  assign wready = wr_take;
  assign arready = rd_take;
  assign acc_addr = wr_take ? awaddr : araddr;

  // full-width arithmetic carries and borrows across the byte boundary
  assign ptr_inc = ptr_r + {{(MEM_ADDR_W-1){1'b0}}, 1'b1};
  assign ptr_dec = ptr_r - {{(MEM_ADDR_W-1){1'b0}}, 1'b1};
  // working register is a signed offset, sign-extended to pointer width
  assign ptr_plus_w = ptr_r + {{HIGH_W{working_r[7]}}, working_r};

  always_comb
  begin
    acc_mode = idap_pkg::PM_NONE;
    unique case (acc_addr)
      idap_pkg::OFF_PORT_PLAIN: acc_mode = idap_pkg::PM_PLAIN;
      idap_pkg::OFF_PORT_POST_INC: acc_mode = idap_pkg::PM_POST_INC;
      idap_pkg::OFF_PORT_POST_DEC: acc_mode = idap_pkg::PM_POST_DEC;
      idap_pkg::OFF_PORT_PRE_INC: acc_mode = idap_pkg::PM_PRE_INC;
      idap_pkg::OFF_PORT_PLUS_WORKING: acc_mode = idap_pkg::PM_PLUS_WORKING;
      default: acc_mode = idap_pkg::PM_NONE;
    endcase
  end

  assign acc_ptr_low = (acc_addr == idap_pkg::OFF_PTR_LOW);
  assign acc_ptr_high = (acc_addr == idap_pkg::OFF_PTR_HIGH);
  assign acc_working = (acc_addr == idap_pkg::OFF_WORKING);
  assign acc_mapped = (acc_mode != idap_pkg::PM_NONE) || acc_ptr_low || acc_ptr_high
                      || acc_working;

  // memory address and pointer value after the access, per port
  always_comb
  begin
    acc_mem_addr = ptr_r;
    acc_ptr_after = ptr_r;
    unique case (acc_mode)
      idap_pkg::PM_PLAIN:
      begin
        acc_mem_addr = ptr_r;
        acc_ptr_after = ptr_r;
      end
      idap_pkg::PM_POST_INC:
      begin
        acc_mem_addr = ptr_r;
        acc_ptr_after = ptr_inc;
      end
      idap_pkg::PM_POST_DEC:
      begin
        acc_mem_addr = ptr_r;
        acc_ptr_after = ptr_dec;
      end
      idap_pkg::PM_PRE_INC:
      begin
        acc_mem_addr = ptr_inc;
        acc_ptr_after = ptr_inc;
      end
      idap_pkg::PM_PLUS_WORKING:
      begin
        acc_mem_addr = ptr_plus_w;
        acc_ptr_after = ptr_r;
      end
      idap_pkg::PM_NONE:
      begin
        acc_mem_addr = ptr_r;
        acc_ptr_after = ptr_r;
      end
    endcase
  end

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    working_nxt = working_r;
    mem_addr_nxt = mem_addr_r;
    mem_wr_nxt = 1'b0;
    mem_rd_nxt = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    rdata_nxt = rdata_r;
    resp_nxt = resp_r;
    unique case (state_r)
      idap_pkg::ST_IDLE:
      begin
        if (wr_take)
        begin
          state_nxt = idap_pkg::ST_BRESP;
          resp_nxt = acc_mapped ? idap_pkg::RESP_OKAY : idap_pkg::RESP_SLVERR;
          // a write without the low byte lane is answered but moves nothing
          if (wstrb[0])
          begin
            if (acc_mode != idap_pkg::PM_NONE)
            begin
              // the byte goes straight to memory, nothing is kept here
              mem_addr_nxt = acc_mem_addr;
              mem_wdata_nxt = wdata[7:0];
              mem_wr_nxt = 1'b1;
              ptr_nxt = acc_ptr_after;
            end
            if (acc_ptr_low)
            begin
              ptr_nxt[7:0] = wdata[7:0];
            end
            if (acc_ptr_high)
            begin
              // only the implemented high bits are kept; the rest read back as zero
              ptr_nxt[MEM_ADDR_W-1:8] = wdata[HIGH_W-1:0];
            end
            if (acc_working)
            begin
              working_nxt = wdata[7:0];
            end
          end
        end
        else if (rd_take)
        begin
          resp_nxt = acc_mapped ? idap_pkg::RESP_OKAY : idap_pkg::RESP_SLVERR;
          rdata_nxt = 32'h0000_0000;
          if (acc_mode != idap_pkg::PM_NONE)
          begin
            state_nxt = idap_pkg::ST_MEM_RD;
            mem_addr_nxt = acc_mem_addr;
            mem_rd_nxt = 1'b1;
            ptr_nxt = acc_ptr_after;
          end
          else
          begin
            state_nxt = idap_pkg::ST_RRESP;
            if (acc_ptr_low)
            begin
              rdata_nxt[7:0] = ptr_r[7:0];
            end
            if (acc_ptr_high)
            begin
              rdata_nxt[HIGH_W-1:0] = ptr_r[MEM_ADDR_W-1:8];
            end
            if (acc_working)
            begin
              rdata_nxt[7:0] = working_r;
            end
          end
        end
      end
      // memory samples the read strobe here and answers one cycle later
      idap_pkg::ST_MEM_RD:
      begin
        state_nxt = idap_pkg::ST_MEM_CAP;
      end
      idap_pkg::ST_MEM_CAP:
      begin
        rdata_nxt = {24'h00_0000, mem_rdata};
        state_nxt = idap_pkg::ST_RRESP;
      end
      idap_pkg::ST_RRESP:
      begin
        if (rready)
        begin
          state_nxt = idap_pkg::ST_IDLE;
        end
      end
      idap_pkg::ST_BRESP:
      begin
        if (bready)
        begin
          state_nxt = idap_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = idap_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // the pointer has no meaningful power-up value; zero is chosen for repeatability
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= idap_pkg::ST_IDLE;
      ptr_r <= '0;
      working_r <= idap_pkg::RST_WORKING;
      mem_addr_r <= '0;
      mem_wr_r <= 1'b0;
      mem_rd_r <= 1'b0;
      mem_wdata_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
      resp_r <= idap_pkg::RESP_OKAY;
    end
    else
    begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      working_r <= working_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wr_r <= mem_wr_nxt;
      mem_rd_r <= mem_rd_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bvalid = (state_r == idap_pkg::ST_BRESP);
  assign bresp = resp_r;
  assign rvalid = (state_r == idap_pkg::ST_RRESP);
  assign rresp = resp_r;
  assign rdata = rdata_r;
  assign mem_addr = mem_addr_r;
  assign mem_wr = mem_wr_r;
  assign mem_rd = mem_rd_r;
  assign mem_wdata = mem_wdata_r;

endmodule : idap_indirect_port

// [rtl/idap_pkg.sv]
// package of constants and types for the indirect data access port
package idap_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_PORT_PLAIN = 8'h00;
  localparam logic [7:0] OFF_PORT_POST_INC = 8'h04;
  localparam logic [7:0] OFF_PORT_POST_DEC = 8'h08;
  localparam logic [7:0] OFF_PORT_PRE_INC = 8'h0c;
  localparam logic [7:0] OFF_PORT_PLUS_WORKING = 8'h10;
  localparam logic [7:0] OFF_PTR_LOW = 8'h14;
  localparam logic [7:0] OFF_PTR_HIGH = 8'h18;
  localparam logic [7:0] OFF_WORKING = 8'h1c;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int DEF_MEM_ADDR_W = 12;
  localparam logic [7:0] RST_WORKING = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEM_RD = 3'b001,
    ST_MEM_CAP = 3'b010,
    ST_RRESP = 3'b011,
    ST_BRESP = 3'b100
  } idap_state_t;

  typedef enum logic [2:0] {
    PM_NONE = 3'b000,
    PM_PLAIN = 3'b001,
    PM_POST_INC = 3'b010,
    PM_POST_DEC = 3'b011,
    PM_PRE_INC = 3'b100,
    PM_PLUS_WORKING = 3'b101
  } idap_port_mode_t;

endpackage : idap_pkg

// [tb/idap_indirect_port_properties.sv]
// assertion checker for the indirect data access port
`timescale 1ns/1ps
module idap_indirect_port_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // memory side
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata
);
  logic aw_t, ar_t;
  assign aw_t = awvalid && awready && wvalid && wready;
  assign ar_t = arvalid && arready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // properties
  // ****
  mem_excl_a: assert property (!(mem_wr && mem_rd)) else $error("memory read and write together");
  wr_answer_a: assert property (aw_t |=> bvalid) else $error("write answer late");
  wr_data_a: assert property (aw_t && awaddr < 8'h14 && awaddr[1:0] == 2'h0 && wstrb[0] |=>
    mem_wr && {24'h0, mem_wdata} == ($past(wdata) & 32'hff)) else $error("port write lost");
  no_strobe_a: assert property (aw_t && !wstrb[0] |=> !mem_wr) else $error("write without strobe");
  rd_seq_a: assert property (ar_t && araddr < 8'h14 && araddr[1:0] == 2'h0 |=>
    mem_rd ##2 rvalid) else $error("port read sequence wrong");
  unmapped_write_a: assert property (aw_t && awaddr == 8'h20 |=> !mem_wr && bresp == 2'h2)
    else $error("unmapped write accepted");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");
  busy_refuse_a: assert property (bvalid || rvalid |-> !awready && !arready)
    else $error("request taken while busy");
  cover property (aw_t && wstrb[0]);
  cover property (ar_t ##1 mem_rd);
  cover property (aw_t && awaddr == 8'h20);
endmodule : idap_indirect_port_properties

// [tb/idap_indirect_port_test.sv]
// self-checking bench for the indirect data access port
`timescale 1ns/1ps
module idap_indirect_port_test;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mem_wr, mem_rd;
  logic [7:0] awaddr, araddr, mem_wdata, mem_rdata;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [11:0] mem_addr;
  int n_fail, samples_checked, i;
  idap_indirect_port u_idap_indirect_port (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .mem_addr, .mem_wr,
    .mem_rd, .mem_wdata, .mem_rdata);
  idap_mem_model u_idap_mem_model (.aclk, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic give_up(input int k);
    if (k >= 40)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask : give_up
  // responses are accepted a cycle late so every answer must stand
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s, input logic e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= {4{s}};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(negedge aclk);
    for (i = 0; i < 40 && awready !== 1'b1; i++) @(negedge aclk);
    give_up(i);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge aclk);
    for (i = 0; i < 40 && bvalid !== 1'b1; i++) @(negedge aclk);
    give_up(i);
    chk(bresp, e ? 2'h2 : 2'h0);
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge aclk);
    for (i = 0; i < 40 && arready !== 1'b1; i++) @(negedge aclk);
    give_up(i);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    for (i = 0; i < 40 && rvalid !== 1'b1; i++) @(negedge aclk);
    give_up(i);
    chk(rdata, {24'h0, d});
    chk(rresp, e ? 2'h2 : 2'h0);
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  // ****
  // tests
  // ****
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h14, 8'h00, 1'b0);
    wr(8'h18, 8'hff, 1'b1, 1'b0);
    rd(8'h18, 8'h0f, 1'b0);
    $display("test layout done");
    wr(8'h18, 8'h00, 1'b1, 1'b0);
    wr(8'h14, 8'hff, 1'b1, 1'b0);
    wr(8'h04, 8'ha1, 1'b1, 1'b0);
    rd(8'h18, 8'h01, 1'b0);
    rd(8'h14, 8'h00, 1'b0);
    wr(8'h0c, 8'hb2, 1'b1, 1'b0);
    rd(8'h08, 8'hb2, 1'b0);
    rd(8'h08, 8'h5a, 1'b0);
    rd(8'h00, 8'ha1, 1'b0);
    rd(8'h14, 8'hff, 1'b0);
    $display("test pointer modes done");
    wr(8'h1c, 8'hfe, 1'b1, 1'b0);
    rd(8'h10, 8'ha7, 1'b0);
    rd(8'h14, 8'hff, 1'b0);
    $display("test offset done");
    wr(8'h00, 8'h33, 1'b0, 1'b0);
    wr(8'h20, 8'h33, 1'b1, 1'b1);
    rd(8'h20, 8'h00, 1'b1);
    rd(8'h00, 8'ha1, 1'b0);
    $display("test refusals done");
    // reads move the pointer too; writes through the post-decrement and plus-working ports
    rd(8'h0c, 8'h5a, 1'b0);
    rd(8'h04, 8'h5a, 1'b0);
    wr(8'h08, 8'h44, 1'b1, 1'b0);
    wr(8'h10, 8'h55, 1'b1, 1'b0);
    rd(8'h10, 8'h55, 1'b0);
    rd(8'h0c, 8'h44, 1'b0);
    rd(8'h14, 8'h01, 1'b0);
    $display("test read updates done");
    report_and_stop();
  end
endmodule : idap_indirect_port_test
bind idap_indirect_port idap_indirect_port_properties u_idap_indirect_port_properties (.aclk,
  .aresetn, .awvalid, .awready, .awaddr, .wdata, .wstrb, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .mem_wr, .mem_rd, .mem_wdata);

// [tb/idap_mem_model.sv]
// data memory model for the indirect data access port
`timescale 1ns/1ps
module idap_mem_model (
  // clock
  input wire logic aclk,
  // memory side
  input wire logic [11:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [4096];
  initial
  begin
    // non-blocking, like the clocked process, so no variable mixes both kinds
    for (int k = 0; k < 4096; k++)
      mem[k] <= 8'(k) ^ 8'h5a;
    mem_rdata <= 8'h00;
  end
  // data toggles outside the answer cycle so a stale byte never matches
  always @(posedge aclk)
  begin
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
endmodule : idap_mem_model
